// [dv/ccd_frontend_output_clamp_control_test.sv]
/*
 Self-checking bench: APB access, pixel latency, blanking, standby, clamp loop.
 Assumes the camera model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "ccf_consts.svh"

module ccd_frontend_output_clamp_control_test;
   import ccf_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, preblank_n = 1'b1;
   logic standby_request = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic black = 1'b0, ob_win = 1'b0, dm_win = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'hf;
   ccf_code_t black_code = 14'h0000, adc_code_a, adc_code_b, pixel_code_out_a, pixel_code_out_b;
   ccf_dac_t  black_offset_dac_a, black_offset_dac_b;
   logic conversion_clock, reference_sample_pulse_n, data_sample_pulse_n, optical_black_clamp_n;
   logic dummy_pixel_clamp_n, powerdown, reference_hold, data_hold, input_clamp_en;
   logic black_offset_charge_a, black_offset_charge_b;
   logic black_offset_discharge_a, black_offset_discharge_b;
   int   n_errors = 0, checked = 0;
   ccf_code_t cd[4] = '{14'h0140, 14'h00f0, 14'h0700, 14'h0700};
   ccf_dac_t  ex[4] = '{10'h1f0, 10'h1f4, 10'h174, 10'h174};

   ccf_camera_model i_cam (.core_clk, .reset, .black, .ob_win, .dm_win, .black_code,
      .conversion_clock, .reference_sample_pulse_n, .data_sample_pulse_n,
      .optical_black_clamp_n, .dummy_pixel_clamp_n, .adc_code_a, .adc_code_b);
   ccf_frontend i_dut (.core_clk, .reset, .clk_en, .conversion_clock,
      .reference_sample_pulse_n, .data_sample_pulse_n, .optical_black_clamp_n,
      .dummy_pixel_clamp_n, .preblank_n, .standby_request, .adc_code_a, .adc_code_b,
      .powerdown, .reference_hold, .data_hold, .input_clamp_en, .pixel_code_out_a,
      .pixel_code_out_b, .black_offset_dac_a, .black_offset_dac_b, .black_offset_charge_a,
      .black_offset_charge_b, .black_offset_discharge_a, .black_offset_discharge_b, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);

   always #5 core_clk = ~core_clk;

   task automatic final_report;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      if (!w)
         cmp(prdata, e);
      cmp({31'h0, pslverr}, {31'h0, er});
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Start of a pixel, well after the last conversion edge has settled the output
   task automatic at_px;
      @(posedge core_clk iff i_cam.ph == 3'h0);
      #1;
   endtask
   task automatic pixels(input int n);
      repeat (n) @(posedge core_clk iff i_cam.ph == 3'h7);
   endtask
   // Checks output after edges 0..10 of a change; code within lo..hi, else zero
   task automatic span(input int lo, input int hi);
      for (int i = 0; i <= 10; i++) begin
         at_px();
         cmp(32'(pixel_code_out_a), (i >= lo && i <= hi) ? 32'(i_cam.code_of(i_cam.pix - 7)) : 0);
         cmp(32'(pixel_code_out_b), (i >= lo && i <= hi) ?
             32'(i_cam.code_of(i_cam.pix - 7) ^ 14'h2aaa) : 0);
      end
   endtask

   initial begin
      #100_000;
      n_errors++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      cmp(32'(black_offset_dac_a), 32'(`CCF_DAC_RST));
      apb(1'b0, `CCF_OFS_CTRL, 32'h0, `CCF_CTRL_RST, 1'b0);
      apb(1'b0, `CCF_OFS_TARGET, 32'h0, 32'(`CCF_TARGET_RST), 1'b0);
      apb(1'b0, `CCF_OFS_DAC_B, 32'h0, 32'(`CCF_DAC_RST), 1'b0);
      apb(1'b1, `CCF_OFS_STATUS, 32'h1, 32'h0, 1'b1);
      apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
      apb(1'b1, `CCF_OFS_TARGET, 32'h0123, 32'h0, 1'b0);
      apb(1'b0, `CCF_OFS_TARGET, 32'h0, 32'h0123, 1'b0);
      pixels(20);
      span(0, 10);
      pixels(1);
      preblank_n <= 1'b0;
      span(0, 8);
      pixels(1);
      preblank_n <= 1'b1;
      span(9, 10);
      pixels(1);
      standby_request <= 1'b1;
      ob_win          <= 1'b1;
      dm_win          <= 1'b1;
      span(11, 11);
      cmp(32'(powerdown), 32'h1);
      cmp(32'(input_clamp_en), 32'h0);
      cmp(32'(black_offset_dac_a), 32'(`CCF_DAC_RST));
      pixels(1);
      ob_win <= 1'b0;
      pixels(1);
      // A logic model needs no analog settling wait
      standby_request <= 1'b0;
      span(8, 10);
      cmp(32'(input_clamp_en), 32'h1);
      pixels(1);
      dm_win <= 1'b0;
      pixels(1);
      at_px();
      cmp(32'(input_clamp_en), 32'h0);
      apb(1'b1, `CCF_OFS_TARGET, 32'h0100, 32'h0, 1'b0);
      black <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `CCF_OFS_CTRL, {24'h0, 7'h20, k < 3}, 32'h0, 1'b0);
         black_code <= cd[k];
         pixels(8);
         ob_win <= 1'b1;
         pixels(4);
         ob_win <= 1'b0;
         pixels(2);
         cmp(32'(black_offset_dac_a), 32'(ex[k]));
         cmp(32'(black_offset_dac_b), 32'(ex[k]));
      end
      // A frozen block keeps its last code and refuses the bus
      black <= 1'b0;
      pixels(8);
      clk_en <= 1'b0;
      pixels(1);
      at_px();
      cmp(32'(pixel_code_out_a), 32'(i_cam.code_of(i_cam.pix - 8)));
      cmp(32'(pready), 32'h0);
      final_report();
   end
endmodule // ccd_frontend_output_clamp_control_test

// [dv/ccf_camera_model.sv]
/*
 Camera timing model: eight core_clk pixels, active-low strobes and clamps.
 Assumes the bench drives the window and black controls on core_clk.
*/
`timescale 1ns/1ps

module ccf_camera_model (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic               black,
   input  wire logic               ob_win,
   input  wire logic               dm_win,
   input  wire ccf_pkg::ccf_code_t black_code,
   output logic                    conversion_clock,
   output logic                    reference_sample_pulse_n,
   output logic                    data_sample_pulse_n,
   output logic                    optical_black_clamp_n,
   output logic                    dummy_pixel_clamp_n,
   output ccf_pkg::ccf_code_t      adc_code_a,
   output ccf_pkg::ccf_code_t      adc_code_b
);
   import ccf_pkg::*;
   logic [2:0] ph   = 3'h0;
   int         pix  = 0;
   logic       ob_q = 1'b0;
   logic       dm_q = 1'b0;
   // Never zero within the run, so a blanked code is always told apart
   function automatic ccf_code_t code_of(input int p);
      return 14'(p * 37 + 5);
   endfunction
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ph  <= 3'h0;
         pix <= 0;
      end else begin
         ph <= ph + 3'h1;
         if (ph == 3'h7) begin
            pix  <= pix + 1;
            ob_q <= ob_win;
            dm_q <= dm_win;
         end
      end
   end
   assign reference_sample_pulse_n = (ph != 3'h0);
   assign data_sample_pulse_n      = (ph != 3'h2);
   assign conversion_clock         = ph[2];
   assign optical_black_clamp_n    = !ob_q;
   assign dummy_pixel_clamp_n      = !dm_q;
   assign adc_code_a               = black ? black_code : code_of(pix);
   assign adc_code_b               = black ? black_code : code_of(pix) ^ 14'h2aaa;
endmodule // ccf_camera_model

// [dv/ccf_props.sv]
/*
 Concurrent checks on the front end pins.
 Assumes every pin is synchronous to core_clk and reset is async high.
*/
`timescale 1ns/1ps

module ccf_props (
   input wire logic               core_clk,
   input wire logic               reset,
   input wire logic               conversion_clock,
   input wire logic               reference_sample_pulse_n,
   input wire logic               data_sample_pulse_n,
   input wire logic               optical_black_clamp_n,
   input wire logic               dummy_pixel_clamp_n,
   input wire logic               preblank_n,
   input wire logic               standby_request,
   input wire logic               powerdown,
   input wire logic               reference_hold,
   input wire logic               data_hold,
   input wire logic               input_clamp_en,
   input wire ccf_pkg::ccf_code_t pixel_code_out_a,
   input wire ccf_pkg::ccf_code_t pixel_code_out_b,
   input wire ccf_pkg::ccf_dac_t  black_offset_dac_a,
   input wire logic               black_offset_charge_a,
   input wire logic               black_offset_discharge_a
);
   import ccf_pkg::*;
   logic       cc_reg, cc_next;
   logic [3:0] blank_reg, blank_next;
   always_comb begin
      cc_next    = conversion_clock;
      blank_next = blank_reg;
      if (preblank_n)
         blank_next = 4'h0;
      else if (conversion_clock && !cc_reg && !standby_request && blank_reg != 4'hf)
         blank_next = blank_reg + 4'h1;
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cc_reg    <= 1'b0;
         blank_reg <= 4'h0;
      end else begin
         cc_reg    <= cc_next;
         blank_reg <= blank_next;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // Three quiet samples cover the one-cycle lag of the DAC update
   sequence s_quiet;
      optical_black_clamp_n [*3];
   endsequence
   property p_blank;
      blank_reg >= 4'h9 |=> pixel_code_out_a == '0 && pixel_code_out_b == '0;
   endproperty
   a_blank: assert property (p_blank) else $error("Output live while blanked");
   property p_sleep_zero;
      standby_request |=> pixel_code_out_a == '0 && pixel_code_out_b == '0;
   endproperty
   a_sleep_zero: assert property (p_sleep_zero) else $error("Output live in standby");
   property p_sleep_both;
      standby_request |-> powerdown;
   endproperty
   a_sleep_both: assert property (p_sleep_both) else $error("No power down");
   property p_dac_still;
      s_quiet |=> $stable(black_offset_dac_a);
   endproperty
   a_dac_still: assert property (p_dac_still) else $error("DAC moved, clamp off");
   property p_dac_dir;
      $changed(black_offset_dac_a) |->
         (black_offset_charge_a && black_offset_dac_a > $past(black_offset_dac_a)) ||
         (black_offset_discharge_a && black_offset_dac_a < $past(black_offset_dac_a));
   endproperty
   a_dac_dir: assert property (p_dac_dir) else $error("DAC step w/o pulse");
   property p_dac_cap;
      $changed(black_offset_dac_a) |->
         (black_offset_dac_a > $past(black_offset_dac_a) ?
          black_offset_dac_a - $past(black_offset_dac_a) :
          $past(black_offset_dac_a) - black_offset_dac_a) <= 10'h020;
   endproperty
   a_dac_cap: assert property (p_dac_cap) else $error("DAC step too large");
   property p_in_clamp;
      input_clamp_en |-> !$past(dummy_pixel_clamp_n) && !$past(reference_sample_pulse_n)
                         && !$past(standby_request);
   endproperty
   a_in_clamp: assert property (p_in_clamp) else $error("Input clamp w/o strobes");
   property p_hold;
      data_hold |-> $past(data_sample_pulse_n) && !$past(data_sample_pulse_n, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("Stray data hold");
   property p_ref_hold;
      reference_hold |-> $past(reference_sample_pulse_n)
                         && !$past(reference_sample_pulse_n, 2);
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("Stray reference hold");
endmodule // ccf_props

bind ccf_frontend ccf_props i_props (.core_clk, .reset, .conversion_clock,
   .reference_sample_pulse_n, .data_sample_pulse_n, .optical_black_clamp_n,
   .dummy_pixel_clamp_n, .preblank_n, .standby_request, .powerdown, .reference_hold, .data_hold,
   .input_clamp_en, .pixel_code_out_a, .pixel_code_out_b, .black_offset_dac_a,
   .black_offset_charge_a, .black_offset_discharge_a);

// [rtl/ccf_clamp_loop.sv]
/*
 Black level clamp loop of one channel: compares the output code with the
 black target and steers a 10-bit current DAC code up or down.
 Assumes step_en is a one-cycle pulse per conversion edge with clamp open.
*/
`timescale 1ns/1ps

`include "ccf_consts.svh"

module ccf_clamp_loop
   import ccf_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   ccf_loop_if.loop  lp
);
   import ccf_pkg::*;

   ccf_dac_t           dac_reg;
   ccf_dac_t           dac_next;
   logic               chg_reg;
   logic               chg_next;
   logic               dis_reg;
   logic               dis_next;
   logic signed [14:0] diff;
   logic [14:0]        mag;
   logic [14:0]        shifted;
   ccf_dac_t           step;
   logic [10:0]        sum;

   always_comb begin
      diff    = $signed({1'b0, lp.code}) - $signed({1'b0, lp.target});
      mag     = diff[14] ? 15'(-diff) : 15'(diff);
      shifted = mag >> lp.shift;
      if (lp.code > `CCF_LINEAR_LIMIT) begin
         step = `CCF_DAC_MAX_STEP;
      end else if (shifted >= 15'(`CCF_DAC_MAX_STEP)) begin
         step = `CCF_DAC_MAX_STEP;
      end else if (shifted == 15'h0000 && mag != 15'h0000) begin
         // Never stall short of the target on a small residue
         step = 10'h001;
      end else begin
         step = shifted[`CCF_DAC_W-1:0];
      end
      dac_next = dac_reg;
      chg_next = 1'b0;
      dis_next = 1'b0;
      sum      = 11'h000;
      if (lp.step_en && lp.enable) begin
         if (diff > 0) begin
            dis_next = 1'b1;
            dac_next = (dac_reg > step) ? dac_reg - step : 10'h000;
         end else if (diff < 0) begin
            chg_next = 1'b1;
            sum      = {1'b0, dac_reg} + {1'b0, step};
            dac_next = sum[10] ? 10'h3ff : sum[9:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dac_reg <= `CCF_DAC_RST;
         chg_reg <= 1'b0;
         dis_reg <= 1'b0;
      end else if (clk_en) begin
         dac_reg <= dac_next;
         chg_reg <= chg_next;
         dis_reg <= dis_next;
      end
   end

   assign lp.dac       = dac_reg;
   assign lp.charge    = chg_reg;
   assign lp.discharge = dis_reg;
endmodule // ccf_clamp_loop

// [rtl/ccf_consts.svh]
`ifndef CCF_CONSTS_SVH
`define CCF_CONSTS_SVH

/*
 Offsets, field positions, reset values and counts of the CCD front end
 output and clamp control. Assumes inclusion by bare name.
*/

`define CCF_CODE_W        14
`define CCF_DAC_W         10
`define CCF_LATENCY       7
`define CCF_BLANK_EDGE    9
`define CCF_LINEAR_LIMIT  14'h0607
`define CCF_DAC_MAX_STEP  10'h020
`define CCF_DAC_RST       10'h200

`define CCF_OFS_CTRL      12'h000
`define CCF_OFS_TARGET    12'h004
`define CCF_OFS_STATUS    12'h008
`define CCF_OFS_DAC_A     12'h00c
`define CCF_OFS_DAC_B     12'h010

`define CCF_CTRL_LOOP_EN  0
`define CCF_CTRL_SHIFT_LO 4
`define CCF_CTRL_SHIFT_HI 7
`define CCF_CTRL_RST      32'h0000_0041
`define CCF_TARGET_RST    14'h0100

`define CCF_ST_STANDBY    0
`define CCF_ST_FILLED     1
`define CCF_ST_BLANK      2
`define CCF_ST_CLAMP      3
`define CCF_ST_IN_CLAMP   4

`endif

// [rtl/ccf_frontend.sv]
/*
 Digital side of a two-channel CCD front end: strobe decode, seven-edge
 output pipeline, preblanking, standby, clamp loops and an APB slave.
 Assumes every pin is synchronous to core_clk, which runs well above the
 conversion clock so that each of its edges is seen.
*/
// How it works
// - Preblank zeroes output at ninth conversion edge
// - Sample appears seven conversion edges later
// - Output register advances on conversion edges
// - Full 14-bit code per channel, unaltered
// - Standby disables blocks, output zero
// - Standby masks strobes and clocks high
// - One standby input serves both channels
// - Loop closes only during black clamp
// - Code difference drives 10-bit DAC direction
// - Loop moves offset toward zero difference
// - One black clamp input drives both channels
// - Above 1543 DAC gives maximum step
// - Sampling timing derived from both strobes
// - Input clamp needs dummy clamp and reference
// - Channels share strobes, paths stay separate
`timescale 1ns/1ps

`include "ccf_consts.svh"

module ccf_frontend
   import ccf_pkg::*;
#(
   // Refill counter is three bits wide, so LAT may not exceed eight
   parameter int LAT = `CCF_LATENCY,
   parameter int BLK = `CCF_BLANK_EDGE
)
(
   input  wire logic              core_clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   input  wire logic              conversion_clock,
   input  wire logic              reference_sample_pulse_n,
   input  wire logic              data_sample_pulse_n,
   input  wire logic              optical_black_clamp_n,
   input  wire logic              dummy_pixel_clamp_n,
   input  wire logic              preblank_n,
   input  wire logic              standby_request,
   input  wire ccf_pkg::ccf_code_t adc_code_a,
   input  wire ccf_pkg::ccf_code_t adc_code_b,
   output logic                   powerdown,
   output logic                   reference_hold,
   output logic                   data_hold,
   output logic                   input_clamp_en,
   output ccf_pkg::ccf_code_t     pixel_code_out_a,
   output ccf_pkg::ccf_code_t     pixel_code_out_b,
   output ccf_pkg::ccf_dac_t      black_offset_dac_a,
   output ccf_pkg::ccf_dac_t      black_offset_dac_b,
   output logic                   black_offset_charge_a,
   output logic                   black_offset_charge_b,
   output logic                   black_offset_discharge_a,
   output logic                   black_offset_discharge_b,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr
);
   import ccf_pkg::*;

   localparam int NCH  = 2;

   // Masked views of the pins: standby holds them all high
   logic conv_m;
   logic ref_m;
   logic dat_m;
   logic obc_m;
   logic dmc_m;
   assign conv_m = conversion_clock | standby_request;
   assign ref_m  = reference_sample_pulse_n | standby_request;
   assign dat_m  = data_sample_pulse_n | standby_request;
   assign obc_m  = optical_black_clamp_n | standby_request;
   assign dmc_m  = dummy_pixel_clamp_n | standby_request;

   // Edge detection state
   logic conv_q_reg;
   logic conv_q_next;
   logic ref_q_reg;
   logic ref_q_next;
   logic dat_q_reg;
   logic dat_q_next;
   logic conv_edge;
   logic ref_trail;
   logic dat_trail;

   assign conv_edge = conv_m & ~conv_q_reg;
   assign ref_trail = ref_m & ~ref_q_reg;
   assign dat_trail = dat_m & ~dat_q_reg;

   always_comb begin
      conv_q_next = conv_m;
      ref_q_next  = ref_m;
      dat_q_next  = dat_m;
   end

   // Sampling and pipeline state
   ccf_code_t       samp_reg [NCH];
   ccf_code_t       samp_next[NCH];
   ccf_code_t       pipe_reg [NCH][LAT-1];
   ccf_code_t       pipe_next[NCH][LAT-1];
   ccf_code_t       out_reg  [NCH];
   ccf_code_t       out_next [NCH];
   logic [BLK-1:0]  blank_reg;
   logic [BLK-1:0]  blank_next;
   ccf_pwr_t        pwr_reg;
   ccf_pwr_t        pwr_next;
   logic [2:0]      fill_reg;
   logic [2:0]      fill_next;
   logic            rhold_reg;
   logic            rhold_next;
   logic            dhold_reg;
   logic            dhold_next;
   logic            iclamp_reg;
   logic            iclamp_next;
   ccf_code_t       raw [NCH];

   assign raw[0] = adc_code_a;
   assign raw[1] = adc_code_b;

   // Power state: one standby pin for both channels
   always_comb begin
      pwr_next  = pwr_reg;
      fill_next = fill_reg;
      case (pwr_reg)
         CCF_PWR_RUN: begin
            if (standby_request) begin
               pwr_next = CCF_PWR_SLEEP;
            end
         end
         CCF_PWR_SLEEP: begin
            fill_next = 3'h0;
            if (!standby_request) begin
               pwr_next = CCF_PWR_FILL;
            end
         end
         CCF_PWR_FILL: begin
            if (standby_request) begin
               pwr_next = CCF_PWR_SLEEP;
            end else if (conv_edge) begin
               if (fill_reg == 3'(LAT - 1)) begin
                  pwr_next = CCF_PWR_RUN;
               end
               fill_next = fill_reg + 3'h1;
            end
         end
         default: pwr_next = CCF_PWR_SLEEP;
      endcase
   end

   logic asleep;
   assign asleep = standby_request | (pwr_reg == CCF_PWR_SLEEP);

   // Datapath: strobe decode, pipeline, blanking
   always_comb begin
      rhold_next  = ref_trail;
      dhold_next  = dat_trail;
      iclamp_next = ~dmc_m & ~ref_m;
      blank_next  = blank_reg;
      for (int c = 0; c < NCH; c++) begin
         samp_next[c] = samp_reg[c];
         out_next[c]  = out_reg[c];
         for (int s = 0; s < LAT - 1; s++) begin
            pipe_next[c][s] = pipe_reg[c][s];
         end
         if (dat_trail) begin
            samp_next[c] = raw[c];
         end
      end
      if (asleep) begin
         blank_next = '0;
         for (int c = 0; c < NCH; c++) begin
            samp_next[c] = '0;
            out_next[c]  = '0;
            for (int s = 0; s < LAT - 1; s++) begin
               pipe_next[c][s] = '0;
            end
         end
      end else if (conv_edge) begin
         blank_next = {blank_reg[BLK-2:0], ~preblank_n};
         for (int c = 0; c < NCH; c++) begin
            pipe_next[c][0] = samp_reg[c];
            for (int s = 1; s < LAT - 1; s++) begin
               pipe_next[c][s] = pipe_reg[c][s-1];
            end
            if (blank_next[BLK-1] || pwr_reg == CCF_PWR_FILL) begin
               out_next[c] = '0;
            end else begin
               out_next[c] = pipe_reg[c][LAT-2];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         conv_q_reg <= 1'b1;
         ref_q_reg  <= 1'b1;
         dat_q_reg  <= 1'b1;
         pwr_reg    <= CCF_PWR_SLEEP;
         fill_reg   <= 3'h0;
         rhold_reg  <= 1'b0;
         dhold_reg  <= 1'b0;
         iclamp_reg <= 1'b0;
         blank_reg  <= '0;
         for (int c = 0; c < NCH; c++) begin
            samp_reg[c] <= '0;
            out_reg[c]  <= '0;
            for (int s = 0; s < LAT - 1; s++) begin
               pipe_reg[c][s] <= '0;
            end
         end
      end else if (clk_en) begin
         conv_q_reg <= conv_q_next;
         ref_q_reg  <= ref_q_next;
         dat_q_reg  <= dat_q_next;
         pwr_reg    <= pwr_next;
         fill_reg   <= fill_next;
         rhold_reg  <= rhold_next;
         dhold_reg  <= dhold_next;
         iclamp_reg <= iclamp_next;
         blank_reg  <= blank_next;
         samp_reg   <= samp_next;
         out_reg    <= out_next;
         pipe_reg   <= pipe_next;
      end
   end

   // Register file
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   ccf_code_t   target_reg;
   ccf_code_t   target_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        err_reg;
   logic        err_next;
   ccf_dac_t    dac [NCH];
   logic        chg [NCH];
   logic        dis [NCH];

   // Clamp loops, one per channel
   for (genvar c = 0; c < NCH; c++) begin : g_loop
      ccf_loop_if lif ();
      assign lif.step_en = conv_edge & ~obc_m & ~asleep;
      assign lif.enable  = ctrl_reg[`CCF_CTRL_LOOP_EN];
      assign lif.code    = pipe_reg[c][LAT-2];
      assign lif.target  = target_reg;
      assign lif.shift   = ctrl_reg[`CCF_CTRL_SHIFT_HI:`CCF_CTRL_SHIFT_LO];
      assign dac[c]      = lif.dac;
      assign chg[c]      = lif.charge;
      assign dis[c]      = lif.discharge;
      ccf_clamp_loop u_loop (
         .core_clk (core_clk),
         .reset    (reset),
         .clk_en   (clk_en),
         .lp       (lif.loop)
      );
   end

   logic setup_ph;
   logic access_ph;
   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;

   // Read data is prepared in setup so that it comes from a flop
   always_comb begin
      ctrl_next   = ctrl_reg;
      target_next = target_reg;
      rdata_next  = rdata_reg;
      err_next    = err_reg;
      if (setup_ph) begin
         rdata_next = 32'h0000_0000;
         err_next   = 1'b0;
         if (paddr == `CCF_OFS_CTRL) begin
            rdata_next = ctrl_reg;
         end else if (paddr == `CCF_OFS_TARGET) begin
            rdata_next = {18'h00000, target_reg};
         end else if (paddr == `CCF_OFS_STATUS) begin
            rdata_next[`CCF_ST_STANDBY]  = asleep;
            rdata_next[`CCF_ST_FILLED]   = (pwr_reg == CCF_PWR_RUN);
            rdata_next[`CCF_ST_BLANK]    = blank_reg[BLK-1];
            rdata_next[`CCF_ST_CLAMP]    = ~obc_m;
            rdata_next[`CCF_ST_IN_CLAMP] = iclamp_reg;
            err_next = pwrite;
         end else if (paddr == `CCF_OFS_DAC_A) begin
            rdata_next = {22'h000000, dac[0]};
            err_next   = pwrite;
         end else if (paddr == `CCF_OFS_DAC_B) begin
            rdata_next = {22'h000000, dac[1]};
            err_next   = pwrite;
         end else begin
            err_next = 1'b1;
         end
      end
      if (access_ph && pwrite && !err_reg) begin
         if (paddr == `CCF_OFS_CTRL && pstrb[0]) begin
            ctrl_next = {24'h000000, pwdata[7:4], 3'h0, pwdata[0]};
         end else if (paddr == `CCF_OFS_TARGET) begin
            if (pstrb[0]) begin
               target_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               target_next[13:8] = pwdata[13:8];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_reg   <= `CCF_CTRL_RST;
         target_reg <= `CCF_TARGET_RST;
         rdata_reg  <= 32'h0000_0000;
         err_reg    <= 1'b0;
      end else if (clk_en) begin
         ctrl_reg   <= ctrl_next;
         target_reg <= target_next;
         rdata_reg  <= rdata_next;
         err_reg    <= err_next;
      end
   end

   // A frozen block must not complete a transfer
   assign pready  = clk_en;
   assign prdata  = access_ph ? rdata_reg : 32'h0000_0000;
   assign pslverr = access_ph & err_reg;

   assign powerdown                = asleep;
   assign reference_hold           = rhold_reg;
   assign data_hold                = dhold_reg;
   assign input_clamp_en           = iclamp_reg;
   assign pixel_code_out_a         = out_reg[0];
   assign pixel_code_out_b         = out_reg[1];
   assign black_offset_dac_a       = dac[0];
   assign black_offset_dac_b       = dac[1];
   assign black_offset_charge_a    = chg[0];
   assign black_offset_charge_b    = chg[1];
   assign black_offset_discharge_a = dis[0];
   assign black_offset_discharge_b = dis[1];
endmodule // ccf_frontend

// [rtl/ccf_loop_if.sv]
/*
 Carrier between the front end control and one channel's clamp loop.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface ccf_loop_if;
   import ccf_pkg::*;
   logic      step_en;
   logic      enable;
   ccf_code_t code;
   ccf_code_t target;
   logic [3:0] shift;
   ccf_dac_t  dac;
   logic      charge;
   logic      discharge;
   modport ctl  (output step_en, output enable, output code, output target,
                 output shift, input dac, input charge, input discharge);
   modport loop (input step_en, input enable, input code, input target,
                 input shift, output dac, output charge, output discharge);
endinterface

// [rtl/ccf_pkg.sv]
/*
 Types shared by the front end control and its clamp loop.
 Assumes ccf_consts.svh is on the include path.
*/
`include "ccf_consts.svh"

package ccf_pkg;
   typedef logic [`CCF_CODE_W-1:0] ccf_code_t;
   typedef logic [`CCF_DAC_W-1:0]  ccf_dac_t;
   typedef enum logic [1:0] {
      CCF_PWR_RUN,
      CCF_PWR_SLEEP,
      CCF_PWR_FILL
   } ccf_pwr_t;
endpackage
